// ---- logic/spf_pkg.sv ----
// Constants, opcodes and state types of the paged flash front end
package spf_pkg;

  // System clock rate, used to turn times into cycle counts
  localparam int CLK_MHZ = 125;

  // Typical internal cycle times in microseconds
  localparam int T_PAGE_REWRITE_US = 11000;
  localparam int T_PAGE_PROGRAM_US = 1200;
  localparam int T_PAGE_ERASE_US   = 10000;
  localparam int T_SECTOR_ERASE_US = 10000;

  // Derived cycle counts for the wait after each internal cycle
  localparam int PAGE_REWRITE_CYCLES = T_PAGE_REWRITE_US * CLK_MHZ;
  localparam int PAGE_PROGRAM_CYCLES = T_PAGE_PROGRAM_US * CLK_MHZ;
  localparam int PAGE_ERASE_CYCLES   = T_PAGE_ERASE_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYCLES = T_SECTOR_ERASE_US * CLK_MHZ;

  // Instruction codes
  localparam logic [7:0] MODIFY_ENABLE_CMD  = 8'h06;
  localparam logic [7:0] MODIFY_DISABLE_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD    = 8'h05;
  localparam logic [7:0] PAGE_REWRITE_CMD   = 8'h0a;
  localparam logic [7:0] PAGE_PROGRAM_CMD   = 8'h02;
  localparam logic [7:0] PAGE_ERASE_CMD     = 8'hdb;
  localparam logic [7:0] SECTOR_ERASE_CMD   = 8'hd8;

  // Array geometry
  localparam int          MEM_BYTES   = 131072;
  localparam int          PAGE_BYTES  = 256;
  localparam logic [15:0] PAGE_LAST   = 16'h00ff;
  localparam logic [15:0] SECTOR_LAST = 16'hffff;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;

  // Address field positions
  localparam int PAGE_MSB = 16;
  localparam int PAGE_LSB = 8;

  // Status byte layout
  localparam int STATUS_CIP_BIT = 0;
  localparam int STATUS_MEL_BIT = 1;

  // Frame byte counts
  localparam logic [2:0] BYTES_OPCODE  = 3'h1;
  localparam logic [2:0] BYTES_ADDRESS = 3'h4;
  localparam logic [2:0] BYTES_DATA    = 3'h5;
  localparam logic [2:0] LAST_ADDRESS  = 3'h3;

  // FIFO shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;

  // Pin reset levels: clock low, select high, reset and protect high
  localparam logic [4:0] PIN_RESET = 5'h0b;

  // Internal cycle sequencer states
  typedef enum logic [5:0] {
    S_IDLE  = 6'b000001,
    S_DRAIN = 6'b000010,
    S_MERGE = 6'b000100,
    S_ERASE = 6'b001000,
    S_PROG  = 6'b010000,
    S_WAIT  = 6'b100000
  } spf_seq_type;

  // Kind of internal cycle
  typedef enum logic [1:0] {
    OP_REWRITE = 2'h0,
    OP_PROGRAM = 2'h1,
    OP_PERASE  = 2'h2,
    OP_SERASE  = 2'h3
  } spf_op_type;

endpackage : spf_pkg

// ---- logic/spf_sync.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module spf_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } spf_sync_state_type;

  spf_sync_state_type r;
  spf_sync_state_type next_r;

  // Meta stage feeds only the stable stage
  always_comb begin
    next_r        = r;
    next_r.meta   = async_in;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= {INIT, INIT};
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.stable;

endmodule : spf_sync
`default_nettype wire

// ---- logic/spf_fifo.sv ----
// Small valid/ready FIFO between serial capture and page buffer
`timescale 1ns/1ns
`default_nettype none
module spf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } spf_fifo_state_type;

  spf_fifo_state_type r;
  spf_fifo_state_type next_r;
  logic               push;
  logic               pop;

  // Pointers wrap naturally, so depth must be a power of two
  always_comb begin
    next_r = r;
    push   = in_valid && in_ready;
    pop    = out_valid && out_ready;
    if (push) begin
      next_r.slot[r.wr] = in_data;
      next_r.wr         = r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = r.rd + 1'b1;
    end
    next_r.count = r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign in_ready  = (r.count != (AW+1)'(DEPTH));
  assign out_valid = (r.count != '0);
  assign out_data  = r.slot[r.rd];

endmodule : spf_fifo
`default_nettype wire

// ---- logic/spf_front_end.sv ----
// Serial front end and page modify engine of a paged serial flash
`timescale 1ns/1ns
`default_nettype none
module spf_front_end #(
  parameter int unsigned REWRITE_WAIT = spf_pkg::PAGE_REWRITE_CYCLES,
  parameter int unsigned PROGRAM_WAIT = spf_pkg::PAGE_PROGRAM_CYCLES,
  parameter int unsigned PERASE_WAIT  = spf_pkg::PAGE_ERASE_CYCLES,
  parameter int unsigned SERASE_WAIT  = spf_pkg::SECTOR_ERASE_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic spi_clk,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  output logic      spi_miso_out,
  output logic      spi_miso_oe_n,
  input  wire logic reset_pin_n,
  input  wire logic write_protect_n,
  output logic      cycle_in_progress_flag,
  output logic      modify_enable_latch,
  output logic      standby_mode,
  output logic      reset_mode
);

  typedef struct packed {
    logic                sclk_prev;
    logic                cs_prev;
    logic                cs_armed;
    logic [7:0]          rx;
    logic [2:0]          bitpos;
    logic [2:0]          bytecnt;
    logic [7:0]          opcode;
    logic [23:0]         addr;
    logic [7:0]          txbyte;
    logic [2:0]          txcnt;
    logic                miso;
    logic                oe_n;
    logic                mel;
    logic                cip;
    logic                standby;
    logic                rstmode;
    logic                buf_ok;
    logic [7:0]          ptr;
    logic [255:0]        mask;
    spf_pkg::spf_seq_type seq;
    spf_pkg::spf_op_type op;
    logic [8:0]          page;
    logic [15:0]         idx;
    logic [31:0]         waitcnt;
  } spf_state_type;

  spf_state_type r;
  spf_state_type next_r;

  // Array and page buffer
  logic [7:0] mem [0:spf_pkg::MEM_BYTES-1];
  logic [7:0] page_buf [0:spf_pkg::PAGE_BYTES-1];

  logic [4:0]  pins_s;
  logic        sclk_s;
  logic        cs_s;
  logic        mosi_s;
  logic        rpin_s;
  logic        wp_s;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic        busy;
  logic [7:0]  byte_in;
  logic [7:0]  status;
  logic        push_valid;
  logic        push_ready;
  logic        drain_valid;
  logic        drain_ready;
  logic [7:0]  drain_data;
  logic        launch;
  logic        mem_we;
  logic [16:0] mem_addr;
  logic [7:0]  mem_rdata;
  logic [7:0]  mem_wdata;
  logic        buf_we;
  logic [7:0]  buf_addr;
  logic [7:0]  buf_wdata;
  logic [7:0]  buf_rdata;

  // Page protection check
  function automatic logic spf_locked(input logic wp, input logic [8:0] pg);
    return !wp && !pg[8];
  endfunction : spf_locked

  // Byte address of the idx-th byte of the current target
  function automatic logic [16:0] spf_target(input logic whole,
                                             input logic [8:0] pg,
                                             input logic [15:0] i);
    return whole ? {pg[8], i} : {pg, i[7:0]};
  endfunction : spf_target

  // Every pin passes two flops before any logic looks at it
  spf_sync #(
    .WIDTH (5),
    .INIT  (spf_pkg::PIN_RESET)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in ({spi_clk, spi_cs_n, spi_mosi, reset_pin_n, write_protect_n}),
    .sync_out (pins_s)
  );

  assign {sclk_s, cs_s, mosi_s, rpin_s, wp_s} = pins_s;

  // Data bytes queue up before the page buffer
  spf_fifo #(
    .WIDTH (spf_pkg::FIFO_WIDTH),
    .DEPTH (spf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (byte_in),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_data)
  );

  // Edge detect on the settled pins; idle level of the clock is irrelevant
  assign sclk_rise = sclk_s && !r.sclk_prev;
  assign sclk_fall = !sclk_s && r.sclk_prev;
  assign cs_rise   = cs_s && !r.cs_prev;
  assign busy      = (r.seq != spf_pkg::S_IDLE);
  assign byte_in   = {r.rx[6:0], mosi_s};
  assign mem_rdata = mem[mem_addr];
  assign buf_rdata = page_buf[r.idx[7:0]];
  // Buffer belongs to the sequencer once merging starts
  assign drain_ready = (r.seq == spf_pkg::S_IDLE) ||
                       (r.seq == spf_pkg::S_DRAIN);

  // Status byte, upper bits read as zero
  always_comb begin
    status = 8'h00;
    status[spf_pkg::STATUS_MEL_BIT] = r.mel;
    status[spf_pkg::STATUS_CIP_BIT] = r.cip;
  end

  // Serial framing, instruction decode and the internal cycle sequencer
  always_comb begin
    next_r     = r;
    push_valid = 1'b0;
    launch     = 1'b0;
    mem_we     = 1'b0;
    mem_wdata  = spf_pkg::ERASED_BYTE;
    buf_we     = 1'b0;
    buf_addr   = r.ptr;
    buf_wdata  = drain_data;
    mem_addr   = spf_target(r.op == spf_pkg::OP_SERASE, r.page, r.idx);
    next_r.sclk_prev = sclk_s;
    next_r.cs_prev   = cs_s;

    // Select falling edge opens a frame and arms the decoder
    if (!cs_s && r.cs_prev && !r.rstmode) begin
      next_r.cs_armed = 1'b1;
      next_r.bitpos   = 3'h0;
      next_r.bytecnt  = 3'h0;
      next_r.txcnt    = 3'h0;
      next_r.opcode   = 8'h00;
    end

    // Shift in one bit per rising edge, MSB first
    if (sclk_rise && !cs_s && r.cs_armed && !r.rstmode) begin
      next_r.rx     = byte_in;
      next_r.bitpos = r.bitpos + 3'h1;
      if (r.bitpos == 3'h7) begin
        if (r.bytecnt == 3'h0) begin
          next_r.opcode = byte_in;
          next_r.buf_ok = 1'b0;
        end else if (r.bytecnt < spf_pkg::BYTES_ADDRESS) begin
          next_r.addr = {r.addr[15:0], byte_in};
        end
        // Third address byte sets the buffer start
        if (r.bytecnt == spf_pkg::LAST_ADDRESS && !busy &&
            (r.opcode == spf_pkg::PAGE_REWRITE_CMD ||
             r.opcode == spf_pkg::PAGE_PROGRAM_CMD)) begin
          next_r.ptr    = byte_in;
          next_r.mask   = '0;
          next_r.buf_ok = 1'b1;
        end
        // Data bytes go to the buffer; a full FIFO drops the byte
        if (r.bytecnt >= spf_pkg::BYTES_ADDRESS && r.buf_ok && !busy) begin
          push_valid = push_ready;
        end
        if (r.bytecnt != spf_pkg::BYTES_DATA) begin
          next_r.bytecnt = r.bytecnt + 3'h1;
        end
      end
    end

    // Status is launched one bit per falling edge and repeats
    if (sclk_fall && !cs_s && r.cs_armed &&
        r.opcode == spf_pkg::STATUS_READ_CMD && r.bytecnt != 3'h0) begin
      next_r.txcnt = r.txcnt + 3'h1;
      if (r.txcnt == 3'h0) begin
        next_r.miso   = status[7];
        next_r.txbyte = {status[6:0], 1'b0};
      end else begin
        next_r.miso   = r.txbyte[7];
        next_r.txbyte = {r.txbyte[6:0], 1'b0};
      end
    end

    // Select rising edge: execute only on a byte boundary
    if (cs_rise && r.cs_armed && !r.rstmode && r.bitpos == 3'h0 &&
        !busy) begin
      next_r.page = r.addr[spf_pkg::PAGE_MSB:spf_pkg::PAGE_LSB];
      unique case (r.opcode)
        spf_pkg::MODIFY_ENABLE_CMD: begin
          if (r.bytecnt == spf_pkg::BYTES_OPCODE) next_r.mel = 1'b1;
        end
        spf_pkg::MODIFY_DISABLE_CMD: begin
          if (r.bytecnt == spf_pkg::BYTES_OPCODE) next_r.mel = 1'b0;
        end
        spf_pkg::PAGE_REWRITE_CMD, spf_pkg::PAGE_PROGRAM_CMD: begin
          launch = r.mel && r.buf_ok &&
                   r.bytecnt == spf_pkg::BYTES_DATA &&
                   !spf_locked(wp_s, next_r.page);
          next_r.op = (r.opcode == spf_pkg::PAGE_REWRITE_CMD) ?
                      spf_pkg::OP_REWRITE : spf_pkg::OP_PROGRAM;
        end
        spf_pkg::PAGE_ERASE_CMD, spf_pkg::SECTOR_ERASE_CMD: begin
          launch = r.mel && r.bytecnt == spf_pkg::BYTES_ADDRESS &&
                   !spf_locked(wp_s, next_r.page);
          next_r.op = (r.opcode == spf_pkg::PAGE_ERASE_CMD) ?
                      spf_pkg::OP_PERASE : spf_pkg::OP_SERASE;
        end
        default: begin
        end
      endcase
      if (launch) begin
        next_r.seq = spf_pkg::S_DRAIN;
      end
    end

    // Buffer fill from the FIFO, wrapping inside the page
    if (drain_valid && drain_ready) begin
      buf_we                = 1'b1;
      next_r.mask[r.ptr]    = 1'b1;
      next_r.ptr            = r.ptr + 8'h01;
    end

    // Sequencer is deaf to the reset pin so cycles always finish
    unique case (r.seq)
      spf_pkg::S_IDLE: begin
      end
      spf_pkg::S_DRAIN: begin
        if (!drain_valid) begin
          next_r.idx = 16'h0000;
          unique case (r.op)
            spf_pkg::OP_REWRITE: next_r.seq = spf_pkg::S_MERGE;
            spf_pkg::OP_PROGRAM: next_r.seq = spf_pkg::S_PROG;
            default:             next_r.seq = spf_pkg::S_ERASE;
          endcase
        end
      end
      spf_pkg::S_MERGE: begin
        // Bytes the master did not send come from the old page
        buf_addr  = r.idx[7:0];
        buf_wdata = mem_rdata;
        buf_we    = !r.mask[r.idx[7:0]];
        next_r.idx = r.idx + 16'h0001;
        if (r.idx == spf_pkg::PAGE_LAST) begin
          next_r.idx = 16'h0000;
          next_r.seq = spf_pkg::S_ERASE;
        end
      end
      spf_pkg::S_ERASE: begin
        mem_we     = 1'b1;
        mem_wdata  = spf_pkg::ERASED_BYTE;
        next_r.idx = r.idx + 16'h0001;
        if (r.idx == ((r.op == spf_pkg::OP_SERASE) ?
                      spf_pkg::SECTOR_LAST : spf_pkg::PAGE_LAST)) begin
          next_r.idx = 16'h0000;
          if (r.op == spf_pkg::OP_REWRITE) begin
            next_r.seq = spf_pkg::S_PROG;
          end else begin
            next_r.seq     = spf_pkg::S_WAIT;
            next_r.waitcnt = (r.op == spf_pkg::OP_SERASE) ?
                             SERASE_WAIT : PERASE_WAIT;
          end
        end
      end
      spf_pkg::S_PROG: begin
        // Programming can only pull bits low
        mem_we     = 1'b1;
        mem_wdata  = mem_rdata & ((r.op == spf_pkg::OP_REWRITE ||
                     r.mask[r.idx[7:0]]) ? buf_rdata :
                     spf_pkg::ERASED_BYTE);
        next_r.idx = r.idx + 16'h0001;
        if (r.idx == spf_pkg::PAGE_LAST) begin
          next_r.idx     = 16'h0000;
          next_r.seq     = spf_pkg::S_WAIT;
          next_r.waitcnt = (r.op == spf_pkg::OP_REWRITE) ?
                           REWRITE_WAIT : PROGRAM_WAIT;
        end
      end
      spf_pkg::S_WAIT: begin
        if (r.waitcnt == 32'h0000_0000) begin
          next_r.seq = spf_pkg::S_IDLE;
          next_r.mel = 1'b0;
        end else begin
          next_r.waitcnt = r.waitcnt - 32'h0000_0001;
        end
      end
      default: begin
        next_r.seq = spf_pkg::S_IDLE;
      end
    endcase

    // Reset pin: latch clears at once, reset mode waits for idle
    if (!rpin_s) begin
      next_r.mel = 1'b0;
    end
    next_r.rstmode = !rpin_s && !busy;
    if (next_r.rstmode) begin
      next_r.cs_armed = 1'b0;
      next_r.bitpos   = 3'h0;
      next_r.bytecnt  = 3'h0;
    end

    // Output drive only while selected and returning status
    next_r.oe_n = !(!cs_s && !next_r.rstmode && r.cs_armed &&
                    next_r.opcode == spf_pkg::STATUS_READ_CMD &&
                    next_r.bytecnt != 3'h0);
    next_r.cip     = (next_r.seq != spf_pkg::S_IDLE);
    next_r.standby = cs_s && (next_r.seq != spf_pkg::S_IDLE) == 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r         <= '0;
      r.sclk_prev <= 1'b0;
      r.cs_prev <= 1'b1;
      r.oe_n    <= 1'b1;
      r.standby <= 1'b1;
      r.seq     <= spf_pkg::S_IDLE;
      r.op      <= spf_pkg::OP_REWRITE;
    end else begin
      r <= next_r;
    end
  end

  // Storage has no reset: contents are data, not control
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (buf_we) begin
      page_buf[buf_addr] <= buf_wdata;
    end
  end

  assign spi_miso_out           = r.miso;
  assign spi_miso_oe_n          = r.oe_n;
  assign cycle_in_progress_flag = r.cip;
  assign modify_enable_latch    = r.mel;
  assign standby_mode           = r.standby;
  assign reset_mode             = r.rstmode;

  // Checks on the serial side and the sequencer
  AST_DESELECT_RELEASE: assert property (@(posedge clk_sys)
    disable iff (!rst_n) cs_s |=> r.oe_n)
    else $error("serial output driven while deselected");

  AST_LAUNCH_ON_FALL: assert property (@(posedge clk_sys)
    disable iff (!rst_n) !$stable(r.miso) |-> $past(sclk_fall))
    else $error("serial output changed without a falling edge");

  AST_CAPTURE_RISE: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    sclk_rise && !cs_s && r.cs_armed && !r.rstmode |=>
    r.rx[0] == $past(mosi_s))
    else $error("input bit not captured on rising edge");

  AST_ARMED_FIRST: assert property (@(posedge clk_sys)
    disable iff (!rst_n) launch |-> r.cs_armed)
    else $error("instruction taken before select fell");

  AST_PROTECT: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    launch |-> !(!wp_s && !r.addr[spf_pkg::PAGE_MSB]))
    else $error("protected page accepted for modify");

  AST_BUSY_FLAG: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $rose(busy) |=> r.cip [*3])
    else $error("busy flag not set during cycle");

  AST_RESET_CLEARS_LATCH: assert property (@(posedge clk_sys)
    disable iff (!rst_n) !rpin_s |=> !r.mel)
    else $error("enable latch survived reset pin");

  AST_RESET_MODE: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    !rpin_s && !busy |=> r.rstmode ##1 r.oe_n)
    else $error("reset mode not entered while idle");

  AST_CYCLE_CONTINUES: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    r.seq == spf_pkg::S_WAIT && r.waitcnt != 32'h0000_0000 |=>
    r.seq == spf_pkg::S_WAIT)
    else $error("internal cycle cut short");

  AST_WRAP: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    buf_we && r.seq != spf_pkg::S_MERGE && r.ptr == 8'hff |=>
    r.ptr == 8'h00)
    else $error("buffer pointer did not wrap in page");

  AST_PROGRAM_AND: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    r.seq == spf_pkg::S_PROG |-> (mem_wdata & ~mem_rdata) == 8'h00)
    else $error("program raised a bit");

endmodule : spf_front_end
`default_nettype wire

// ---- verification/spf_master_model.sv ----
// Serial bus master model for the paged flash front end
`timescale 1ns/1ns
`default_nettype none
module spf_master_model (
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso_out
);
  logic       pol;
  logic [7:0] rx;
  // Deselected with clock parked low
  initial begin
    pol = 1'b0;
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Park clock at the mode's idle level, then select
  task automatic start(input logic p);
    pol = p;
    spi_clk = p;
    #125 spi_cs_n = 1'b0;
  endtask : start
  // Launch in the low phase, sample on the rise, MSB first
  task automatic shift(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      spi_clk = 1'b0;
      spi_mosi = b[i];
      #62 spi_clk = 1'b1;
      rx = {rx[6:0], spi_miso_out};
      #63;
    end
  endtask : shift
  // Flip data on deselect so a stale bit never looks valid
  task automatic stop;
    spi_clk = pol;
    #63 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #500;
  endtask : stop
endmodule : spf_master_model
`default_nettype wire

// ---- verification/spf_front_end_tb.sv ----
// Self-checking bench for the paged flash front end
`timescale 1ns/1ns
`default_nettype none
module spf_front_end_tb;
  logic clk_sys, rst_n, reset_pin_n, write_protect_n, spi_clk, spi_cs_n;
  logic spi_mosi, spi_miso_out, spi_miso_oe_n, cycle_in_progress_flag;
  logic modify_enable_latch, standby_mode, reset_mode, spi_miso_seen;
  int         err_count, samples_checked, seed;
  logic [7:0] d [3];
  logic [7:0] ref_mem [int];
  spf_front_end #(.REWRITE_WAIT(20), .PROGRAM_WAIT(20), .PERASE_WAIT(20),
    .SERASE_WAIT(20)) spf_front_end_i (.clk_sys, .rst_n, .spi_clk,
    .spi_cs_n, .spi_mosi, .spi_miso_out, .spi_miso_oe_n, .reset_pin_n,
    .write_protect_n, .cycle_in_progress_flag, .modify_enable_latch,
    .standby_mode, .reset_mode);
  // Released output reads as the inverse so a stale bit never passes
  assign spi_miso_seen = spi_miso_oe_n ? ~spi_miso_out : spi_miso_out;
  spf_master_model spf_master_model_i (.spi_clk, .spi_cs_n, .spi_mosi,
    .spi_miso_out (spi_miso_seen));
  // System clock, 8 ns
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic status(input logic p, input logic [7:0] exp);
    spf_master_model_i.start(p);
    spf_master_model_i.shift(8'h05, 8);
    chk({7'h00, spi_miso_oe_n}, 8'h00);
    spf_master_model_i.shift(8'h00, 8);
    spf_master_model_i.stop;
    chk(spf_master_model_i.rx, exp);
    chk({7'h00, spi_miso_oe_n}, 8'h01);
  endtask : status
  // Opcode of some bits, address unless n is negative, n data bytes
  task automatic frame(input logic [7:0] op, input int bits,
                       input logic [23:0] a, input int n);
    spf_master_model_i.start(1'b0);
    spf_master_model_i.shift(op, bits);
    if (n >= 0)
      for (int i = 16; i >= 0; i -= 8) spf_master_model_i.shift(a[i+:8], 8);
    for (int i = 0; i < n; i++) spf_master_model_i.shift(d[i], 8);
    spf_master_model_i.stop;
  endtask : frame
  // Bounded poll on the busy flag
  task automatic idle_wait;
    for (int i = 0; i < 4000 && cycle_in_progress_flag !== 1'b0; i++)
      @(posedge clk_sys);
    if (cycle_in_progress_flag !== 1'b0) begin
      err_count++;
      $display("mismatch at %0t: busy flag never cleared", $time);
    end
  endtask : idle_wait
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // Watchdog, far beyond the expected run of some 70 us
  initial begin
    #400000 err_count++;
    give_verdict;
  end
  initial begin
    seed = 69;
    {err_count, samples_checked} = '0;
    // Reset pin low through power on, released after the system reset
    {rst_n, reset_pin_n, write_protect_n} = 3'h1;
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 reset_pin_n = 1'b1;
    #500 chk({7'h00, standby_mode}, 8'h01);
    status(1'b0, 8'h00);
    frame(8'h06, 7, 24'h0, -1);
    status(1'b1, 8'h00);
    frame(8'h06, 8, 24'h0, -1);
    status(1'b1, 8'h02);
    @(posedge clk_sys) #1 write_protect_n = 1'b0;
    for (int i = 0; i < 3; i++) d[i] = 8'($random(seed));
    frame(8'h02, 8, 24'h00_05_10, 3);
    chk({6'h0, modify_enable_latch, cycle_in_progress_flag}, 8'h02);
    frame(8'hd8, 8, 24'h00_80_00, 0);
    chk({6'h0, modify_enable_latch, cycle_in_progress_flag}, 8'h02);
    $display("protect test done");
    @(posedge clk_sys) #1 write_protect_n = 1'b1;
    // Erase the target page first so the merge reads known bytes
    frame(8'hdb, 8, 24'h01_23_00, 0);
    idle_wait;
    frame(8'h06, 8, 24'h0, -1);
    frame(8'h0a, 8, 24'hff_23_fe, 3);
    chk({6'h0, standby_mode, cycle_in_progress_flag}, 8'h01);
    status(1'b0, 8'h03);
    idle_wait;
    for (int i = 0; i < 3; i++) ref_mem[32'h12300 + (254 + i) % 256] = d[i];
    ref_mem[32'h12310] = 8'hff;
    status(1'b0, 8'h00);
    foreach (ref_mem[k]) chk(spf_front_end_i.mem[k], ref_mem[k]);
    $display("rewrite test done");
    frame(8'h06, 8, 24'h0, -1);
    d[0] = 8'h0f;
    frame(8'h02, 8, 24'h01_23_fe, 1);
    @(posedge clk_sys) #1 reset_pin_n = 1'b0;
    repeat (20) @(posedge clk_sys);
    chk({6'h0, reset_mode, cycle_in_progress_flag}, 8'h01);
    idle_wait;
    repeat (4) @(posedge clk_sys);
    chk({5'h0, spi_miso_oe_n, reset_mode, modify_enable_latch}, 8'h06);
    ref_mem[32'h123fe] &= 8'h0f;
    foreach (ref_mem[k]) chk(spf_front_end_i.mem[k], ref_mem[k]);
    @(posedge clk_sys) #1 reset_pin_n = 1'b1;
    status(1'b0, 8'h00);
    // Latch set again after the reset pin, then cleared by disable
    frame(8'h06, 8, 24'h0, -1);
    status(1'b1, 8'h02);
    frame(8'h04, 8, 24'h0, -1);
    status(1'b0, 8'h00);
    $display("program test done");
    give_verdict;
  end
endmodule : spf_front_end_tb
`default_nettype wire
